// File: rtl/ctm_ctrl.sv
/*
  ctm_ctrl: mode sequencing and bus wake handling of the can transceiver.
  assumes chip mode, spi commands and wake register reads come from same-clock logic;
  bus receiver level and rx pin readback are asynchronous and are synchronised here.
*/
// What this block does
// - normal mode only by command, allowed chip modes
// - normal mode drives bus from tx input
// - rx pin monitored, failure recorded for spi
// - receive only mode offered for diagnostics
// - bus rates up to 1 Mbaud supported
// - wake capable by command, forced in fail-safe
// - after wake, rearm only via other mode
// - wake needs activity longer than filter time
// - sleep wake: restart, rx low, flag, int high
// - no interrupt when leaving sleep
// - wake source readable at register 000
// - stop wake: flag, int low, rx low, stay
// - restart/fail-safe wake: flag, int high, restart
// - normal wake: flag, int low, rx low
// - wake interrupt only when unmasked
// - off by command, forced in init/factory
// - off mode ignores all bus wake activity
// - receive only disables driver, keeps receiver
`timescale 1ns/1ps
module ctm_ctrl
  import ctm_pkg::*;
#(
  parameter int WAKE_FILTER_CYC = ctm_pkg::CTM_WAKE_FILTER_CYC,
  parameter int RXFAIL_CYC      = ctm_pkg::CTM_RXFAIL_CYC,
  parameter int FIFO_DEPTH      = ctm_pkg::CTM_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // chip state
  input  wire ctm_pkg::ctm_chip_type    chip_mode,
  output logic                          chip_go_restart,
  // spi side
  input  wire logic                     mode_cmd_valid,
  input  wire ctm_pkg::ctm_can_type     mode_cmd,
  input  wire logic                     wake_int_mask,
  input  wire logic                     reg_rd_valid,
  input  wire logic [7:0]               reg_rd_addr,
  output logic                          can_wake_flag,
  output logic                          rx_fail_flag,
  output ctm_pkg::ctm_can_type          can_mode,
  // host protocol controller
  input  wire logic                     can_tx_input,
  output logic                          can_rx_output,
  // received bit stream, bytes towards a diagnostic reader
  output logic                          rx_byte_valid,
  input  wire logic                     rx_byte_ready,
  output logic [ctm_pkg::CTM_FIFO_WIDTH-1:0] rx_byte_data,
  output logic                          rx_overrun,
  // analog front end
  input  wire logic                     bus_dominant,
  input  wire logic                     can_rx_pin,
  output logic                          drv_dominant,
  output logic                          drv_enable,
  output logic                          rcv_enable,
  output logic                          lp_rcv_enable,
  // interrupt pin, active low
  output logic                          interrupt_out_n
);
  import ctm_pkg::*;

  localparam int FW = CTM_FIFO_WIDTH;

  // ==========================================================
  // synchronisers for asynchronous inputs
  logic [1:0] bus_sync_q;
  logic [1:0] pin_sync_q;
  logic       bus_dom;
  logic       pin_level;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_sync_q <= 2'h0;
      pin_sync_q <= 2'h3;
    end else begin
      bus_sync_q <= {bus_sync_q[0], bus_dominant};
      pin_sync_q <= {pin_sync_q[0], can_rx_pin};
    end
  end
  assign bus_dom   = bus_sync_q[1];
  assign pin_level = pin_sync_q[1];

  // ==========================================================
  // mode selection
  ctm_can_type mode_q;
  logic        wake_seen_q;
  logic        wake_event;
  logic        may_normal;
  logic        may_lowpwr;
  logic        force_off;
  logic        force_wake;
  logic        cmd_ok;
  // sw development mode is folded into the sw flash code of the chip mode
  assign may_normal = (chip_mode == CTM_CHIP_NORMAL) || (chip_mode == CTM_CHIP_SWFLASH);
  assign may_lowpwr = (chip_mode == CTM_CHIP_NORMAL) || (chip_mode == CTM_CHIP_STOP)
                   || (chip_mode == CTM_CHIP_SLEEP) || (chip_mode == CTM_CHIP_RESTART);
  assign force_off  = (chip_mode == CTM_CHIP_INIT) || (chip_mode == CTM_CHIP_FACTORY);
  assign force_wake = (chip_mode == CTM_CHIP_FAILSAFE);

  always_comb begin
    cmd_ok = 1'b0;
    unique case (mode_cmd)
      CTM_CAN_NORMAL: cmd_ok = may_normal;
      CTM_CAN_RXONLY: cmd_ok = (chip_mode == CTM_CHIP_NORMAL);
      CTM_CAN_OFF:    cmd_ok = may_lowpwr;
      CTM_CAN_WAKE:   cmd_ok = may_lowpwr && !wake_seen_q;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= CTM_CAN_OFF;
    end else if (force_off) begin
      mode_q <= CTM_CAN_OFF;
    end else if (force_wake) begin
      mode_q <= CTM_CAN_WAKE;
    end else if (mode_cmd_valid && cmd_ok) begin
      mode_q <= mode_cmd;
    end
  end
  assign can_mode = mode_q;

  // lock against rearming: cleared only by passing through another mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_seen_q <= 1'b0;
    end else if (wake_event) begin
      wake_seen_q <= 1'b1;
    end else if (mode_q != CTM_CAN_WAKE) begin
      wake_seen_q <= 1'b0;
    end
  end

  // ==========================================================
  // wake filter: dominant must persist beyond the filter time
  localparam int WCW = $clog2(WAKE_FILTER_CYC + 2);
  logic [WCW-1:0] wcnt_q;
  logic           armed;
  assign armed = (mode_q == CTM_CAN_WAKE) && !wake_seen_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wcnt_q <= '0;
    end else if (!armed || !bus_dom) begin
      wcnt_q <= '0;
    end else if (wcnt_q <= WCW'(WAKE_FILTER_CYC)) begin
      wcnt_q <= wcnt_q + 1'b1;
    end
  end
  assign wake_event = armed && bus_dom && (wcnt_q == WCW'(WAKE_FILTER_CYC));

  // ==========================================================
  // wake flag and register read
  logic flag_q;
  logic wake_rd;
  assign wake_rd = reg_rd_valid && (reg_rd_addr == CTM_WAKE_REG_ADDR);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_q <= CTM_RESET_WAKE_FLAG;
    end else if (wake_event) begin
      flag_q <= 1'b1; // set wins over read clear
    end else if (wake_rd) begin
      flag_q <= 1'b0;
    end
  end
  assign can_wake_flag = flag_q;

  // ==========================================================
  // interrupt and chip restart request
  logic int_q;
  logic restart_q;
  logic int_mode;
  // no interrupt on sleep, restart or fail-safe wakes
  assign int_mode = (chip_mode == CTM_CHIP_STOP) || (chip_mode == CTM_CHIP_NORMAL);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_q <= 1'b0;
    end else if (wake_event && int_mode && !wake_int_mask) begin
      int_q <= 1'b1;
    end else if (wake_rd) begin
      int_q <= 1'b0;
    end
  end
  assign interrupt_out_n = !int_q;

  // stop and normal remain; restart stays restart
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wake_event && ((chip_mode == CTM_CHIP_SLEEP)
                 || (chip_mode == CTM_CHIP_FAILSAFE));
    end
  end
  assign chip_go_restart = restart_q;

  // ==========================================================
  // rx output: pulled low from a wake until the host leaves wake mode
  logic rx_hold_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_hold_q <= 1'b0;
    end else if (wake_event) begin
      rx_hold_q <= 1'b1;
    end else if (mode_q != CTM_CAN_WAKE) begin
      rx_hold_q <= 1'b0;
    end
  end

  logic rx_out_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_out_q <= 1'b1;
    end else if (rx_hold_q || wake_event) begin
      rx_out_q <= 1'b0;
    end else if (rcv_enable) begin
      rx_out_q <= !bus_dom; // two sync plus one register, well inside a 1 Mbaud bit
    end else begin
      rx_out_q <= 1'b1;
    end
  end
  assign can_rx_output = rx_out_q;

  // ==========================================================
  // driver and receiver enables
  assign drv_enable    = (mode_q == CTM_CAN_NORMAL);
  assign drv_dominant  = drv_enable && !can_tx_input;
  assign rcv_enable    = (mode_q == CTM_CAN_NORMAL) || (mode_q == CTM_CAN_RXONLY);
  assign lp_rcv_enable = (mode_q == CTM_CAN_WAKE);

  // ==========================================================
  // rx pin diagnosis: pin stays recessive while the bus toggles
  localparam int RCW = $clog2(RXFAIL_CYC + 2);
  logic [RCW-1:0] rcnt_q;
  logic           fail_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rcnt_q <= '0;
      fail_q <= 1'b0;
    end else begin
      if (!rcv_enable || !pin_level || rx_hold_q) begin
        rcnt_q <= '0;
      end else if (bus_dom && rcnt_q < RCW'(RXFAIL_CYC)) begin
        rcnt_q <= rcnt_q + 1'b1;
      end
      // set only on reaching the limit, so a read can clear it while the count saturates
      if (rcv_enable && pin_level && !rx_hold_q && bus_dom && rcnt_q == RCW'(RXFAIL_CYC - 1)) begin
        fail_q <= 1'b1;
      end else if (wake_rd) begin
        fail_q <= 1'b0;
      end
    end
  end
  assign rx_fail_flag = fail_q;

  // ==========================================================
  // received bits sampled in the last cycle of each bit time counted from receiver enable, packed lsb first into bytes
  localparam int BCW = $clog2(CTM_BIT_CYC + 1);
  logic [BCW-1:0] bcnt_q;
  logic [FW-1:0]  sh_q;
  logic [2:0]     nbit_q;
  logic           byte_v_q;
  logic           fifo_in_ready;
  logic           ovr_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bcnt_q   <= '0;
      sh_q     <= '0;
      nbit_q   <= 3'h0;
      byte_v_q <= 1'b0;
    end else begin
      byte_v_q <= 1'b0;
      if (!rcv_enable) begin
        bcnt_q <= '0;
        nbit_q <= 3'h0;
      end else if (bcnt_q == BCW'(CTM_BIT_CYC - 1)) begin
        bcnt_q <= '0;
        sh_q   <= {!bus_dom, sh_q[FW-1:1]};
        nbit_q <= nbit_q + 1'b1;
        byte_v_q <= (nbit_q == 3'h7);
      end else begin
        bcnt_q <= bcnt_q + 1'b1;
      end
    end
  end

  // a full fifo drops the byte and flags it; the bus cannot be held off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else if (byte_v_q && !fifo_in_ready) begin
      ovr_q <= 1'b1;
    end else if (wake_rd) begin
      ovr_q <= 1'b0;
    end
  end
  assign rx_overrun = ovr_q;

  ctm_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .in_valid (byte_v_q),
    .in_ready (fifo_in_ready),
    .in_data  (sh_q),
    .out_valid(rx_byte_valid),
    .out_ready(rx_byte_ready),
    .out_data (rx_byte_data),
    .full     (),
    .empty    ()
  );

  // ==========================================================
  // checks
  sequence s_wake_in_off;
    mode_q == CTM_CAN_OFF && bus_dom;
  endsequence
  chk_off_no_flag : assert property (@(posedge ref_clk) disable iff (rst)
    s_wake_in_off |-> !wake_event)
    else $error("wake accepted in off mode");
  chk_wake_sets_flag : assert property (@(posedge ref_clk) disable iff (rst)
    wake_event |=> can_wake_flag)
    else $error("wake did not set flag");
  chk_flag_holds : assert property (@(posedge ref_clk) disable iff (rst)
    can_wake_flag && !wake_rd |=> can_wake_flag)
    else $error("wake flag dropped without read");
  chk_filter_time : assert property (@(posedge ref_clk) disable iff (rst)
    wake_event |-> $past(bus_dom, 2) && $past(armed, 2))
    else $error("wake without persistent activity");
  chk_no_int_sleep : assert property (@(posedge ref_clk) disable iff (rst)
    wake_event && chip_mode == CTM_CHIP_SLEEP && !int_q |=> interrupt_out_n)
    else $error("interrupt raised on sleep wake");
  chk_int_masked : assert property (@(posedge ref_clk) disable iff (rst)
    wake_event && wake_int_mask && !int_q |=> interrupt_out_n)
    else $error("masked wake pulled interrupt low");
  chk_int_normal : assert property (@(posedge ref_clk) disable iff (rst)
    wake_event && chip_mode == CTM_CHIP_NORMAL && !wake_int_mask |=> !interrupt_out_n)
    else $error("normal mode wake gave no interrupt");
  chk_rx_low_wake : assert property (@(posedge ref_clk) disable iff (rst)
    wake_event |=> !can_rx_output ##1 !can_rx_output)
    else $error("rx output not low after wake");
  chk_sleep_restart : assert property (@(posedge ref_clk) disable iff (rst)
    wake_event && chip_mode == CTM_CHIP_SLEEP |=> chip_go_restart)
    else $error("sleep wake did not request restart");
  chk_no_rearm : assert property (@(posedge ref_clk) disable iff (rst)
    wake_event |=> !armed)
    else $error("wake mode rearmed directly");
  chk_driver_off : assert property (@(posedge ref_clk) disable iff (rst)
    mode_q != CTM_CAN_NORMAL |-> !drv_dominant)
    else $error("driver active outside normal mode");
  chk_forced_off : assert property (@(posedge ref_clk) disable iff (rst)
    force_off |=> mode_q == CTM_CAN_OFF)
    else $error("init mode did not force off");
endmodule

// File: rtl/ctm_fifo.sv
/*
  ctm_fifo: synchronous fifo with valid/ready on both sides.
  assumes one clock and an asynchronous active high reset.
*/
`timescale 1ns/1ps
module ctm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // state
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign full      = (cnt_q == (AW+1)'(DEPTH));
  assign empty     = (cnt_q == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_q[rd_q];

  // ==========================================================
  // storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // ==========================================================
  // pointers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_fifo_no_overflow : assert property (@(posedge ref_clk) disable iff (rst)
    full && !pop |=> full)
    else $error("fifo count moved while full without a pop");
endmodule

// File: rtl/ctm_pkg.sv
/*
  ctm_pkg: constants and types for the can transceiver mode and wake control.
  assumes a single 200 MHz clock domain.
*/
package ctm_pkg;
  // ==========================================================
  // chip operating modes, as reported by the system controller
  typedef enum logic [2:0] {
    CTM_CHIP_INIT,
    CTM_CHIP_NORMAL,
    CTM_CHIP_STOP,
    CTM_CHIP_SLEEP,
    CTM_CHIP_RESTART,
    CTM_CHIP_FAILSAFE,
    CTM_CHIP_SWFLASH,
    CTM_CHIP_FACTORY
  } ctm_chip_type;

  // ==========================================================
  // transceiver modes
  typedef enum logic [1:0] {
    CTM_CAN_OFF,
    CTM_CAN_NORMAL,
    CTM_CAN_RXONLY,
    CTM_CAN_WAKE
  } ctm_can_type;

  // ==========================================================
  // timing
  localparam int  CTM_CLK_MHZ         = 200;
  localparam int  CTM_WAKE_FILTER_NS  = 500;
  localparam int  CTM_WAKE_FILTER_CYC = (CTM_WAKE_FILTER_NS * CTM_CLK_MHZ + 999) / 1000;
  localparam int  CTM_MAX_BAUD        = 1000000;
  localparam int  CTM_BIT_CYC         = CTM_CLK_MHZ * 1000000 / CTM_MAX_BAUD;
  // rx pin judged stuck recessive after this many bit times of bus activity
  localparam int  CTM_RXFAIL_BITS     = 16;
  localparam int  CTM_RXFAIL_CYC      = CTM_RXFAIL_BITS * CTM_BIT_CYC;
  localparam int  CTM_FIFO_DEPTH      = 8;
  localparam int  CTM_FIFO_WIDTH      = 8;
  localparam logic [7:0] CTM_WAKE_REG_ADDR = 8'h00;
  localparam logic CTM_RESET_WAKE_FLAG = 1'b0;
endpackage

// File: test/ctm_bus_model.sv
/*
  ctm_bus_model: far side of the transceiver, the bus wire and the rx pin readback.
  assumes the bench drives remote traffic and may clamp the rx pin recessive.
*/
`timescale 1ns/1ps
module ctm_bus_model (
  // local driver
  input  wire logic drv_dominant,
  input  wire logic drv_enable,
  // remote nodes and fault injection
  input  wire logic remote_dominant,
  input  wire logic stuck_rx_high,
  // pins
  input  wire logic can_rx_output,
  output logic      bus_dominant,
  output logic      can_rx_pin
);
  // ==========================================================
  // wired bus: any dominant driver wins
  assign bus_dominant = (drv_enable & drv_dominant) | remote_dominant;
  // a shorted rx pin reads recessive whatever the transceiver drives
  assign can_rx_pin   = stuck_rx_high ? 1'b1 : can_rx_output;
endmodule

// File: test/tb_top.sv
/*
  tb_top: self-checking bench for ctm_ctrl, command and read tasks plus bus pulses.
  assumes ctm_ctrl with shortened filter counts and the bus model beside it.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
  import ctm_pkg::*;
  localparam int WF = 4;
  localparam int RF = 20;
  // ==========================================================
  // signals
  logic         ref_clk         = 1'b0;
  logic         rst             = 1'b1;
  ctm_chip_type chip_mode       = CTM_CHIP_NORMAL;
  logic         mode_cmd_valid  = 1'b0;
  ctm_can_type  mode_cmd        = CTM_CAN_OFF;
  logic         wake_int_mask   = 1'b0;
  logic         reg_rd_valid    = 1'b0;
  logic [7:0]   reg_rd_addr     = 8'h00;
  logic         can_tx_input    = 1'b1;
  logic         rx_byte_ready   = 1'b1;
  logic         remote_dominant = 1'b0;
  logic         stuck_rx_high   = 1'b0;
  logic         chip_go_restart, can_wake_flag, rx_fail_flag, can_rx_output;
  logic         rx_byte_valid, rx_overrun, bus_dominant, can_rx_pin;
  logic         drv_dominant, drv_enable, rcv_enable, lp_rcv_enable, interrupt_out_n;
  logic [7:0]   rx_byte_data;
  ctm_can_type  can_mode;
  int           n_mismatch      = 0;
  int           cmp_count       = 0;
  int           n_go            = 0;

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (chip_go_restart === 1'b1) n_go++;

  ctm_ctrl #(.WAKE_FILTER_CYC(WF), .RXFAIL_CYC(RF), .FIFO_DEPTH(CTM_FIFO_DEPTH)) i_ctm_ctrl (
    .ref_clk(ref_clk), .rst(rst), .chip_mode(chip_mode), .chip_go_restart(chip_go_restart),
    .mode_cmd_valid(mode_cmd_valid), .mode_cmd(mode_cmd), .wake_int_mask(wake_int_mask),
    .reg_rd_valid(reg_rd_valid), .reg_rd_addr(reg_rd_addr), .can_wake_flag(can_wake_flag),
    .rx_fail_flag(rx_fail_flag), .can_mode(can_mode), .can_tx_input(can_tx_input),
    .can_rx_output(can_rx_output), .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
    .rx_byte_data(rx_byte_data), .rx_overrun(rx_overrun), .bus_dominant(bus_dominant),
    .can_rx_pin(can_rx_pin), .drv_dominant(drv_dominant), .drv_enable(drv_enable),
    .rcv_enable(rcv_enable), .lp_rcv_enable(lp_rcv_enable), .interrupt_out_n(interrupt_out_n));

  ctm_bus_model i_ctm_bus_model (
    .drv_dominant(drv_dominant), .drv_enable(drv_enable), .remote_dominant(remote_dominant),
    .stuck_rx_high(stuck_rx_high), .can_rx_output(can_rx_output), .bus_dominant(bus_dominant),
    .can_rx_pin(can_rx_pin));

  // ==========================================================
  // access tasks
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmd(input ctm_can_type m);
    @(posedge ref_clk);
    mode_cmd_valid <= 1'b1;
    mode_cmd       <= m;
    @(posedge ref_clk);
    mode_cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd_valid <= 1'b1;
    reg_rd_addr  <= a;
    @(posedge ref_clk);
    reg_rd_valid <= 1'b0;
    step(1);
  endtask
  task automatic set_chip(input ctm_chip_type c);
    @(posedge ref_clk);
    chip_mode <= c;
    step(2);
  endtask
  // remote node holds the bus dominant for n cycles, then releases it
  task automatic bus_pulse(input int n);
    @(posedge ref_clk);
    remote_dominant <= 1'b1;
    repeat (n) @(posedge ref_clk);
    remote_dominant <= 1'b0;
    step(8);
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // wake reaction for one chip mode
  task automatic wake_case(input ctm_chip_type cm, input logic msk, input logic exp_n, input int exp_go);
    int g0;
    g0 = n_go;
    @(posedge ref_clk);
    wake_int_mask <= msk;
    set_chip(CTM_CHIP_NORMAL);
    cmd(CTM_CAN_OFF);
    set_chip(cm);
    if (cm != CTM_CHIP_FAILSAFE) cmd(CTM_CAN_WAKE);
    `CHK(can_mode, CTM_CAN_WAKE)
    `CHK(lp_rcv_enable, 1'b1)
    bus_pulse(WF - 1);
    `CHK(can_wake_flag, 1'b0)
    bus_pulse(3 * WF);
    `CHK(can_wake_flag, 1'b1)
    `CHK(interrupt_out_n, exp_n)
    `CHK(can_rx_output, 1'b0)
    `CHK(n_go - g0, exp_go)
    `CHK(can_mode, CTM_CAN_WAKE)
    rd(8'h01);
    `CHK(can_wake_flag, 1'b1)
    rd(CTM_WAKE_REG_ADDR);
    `CHK(can_wake_flag, 1'b0)
    `CHK(interrupt_out_n, 1'b1)
    if (cm != CTM_CHIP_FAILSAFE) begin
      cmd(CTM_CAN_WAKE);
      bus_pulse(3 * WF);
      `CHK(can_wake_flag, 1'b0)
    end
  endtask

  ctm_chip_type refuse_tab[3] = '{CTM_CHIP_STOP, CTM_CHIP_SLEEP, CTM_CHIP_RESTART};
  ctm_chip_type wk_chip[7]    = '{CTM_CHIP_NORMAL, CTM_CHIP_NORMAL, CTM_CHIP_STOP, CTM_CHIP_STOP,
                                  CTM_CHIP_SLEEP, CTM_CHIP_RESTART, CTM_CHIP_FAILSAFE};
  logic         wk_mask[7]    = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic         wk_int_n[7]   = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  int           wk_go[7]      = '{0, 0, 0, 0, 1, 0, 1};

  // ==========================================================
  // watchdog, sized well above the fifo fill time
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    step(1);
    `CHK(can_mode, CTM_CAN_OFF)
    `CHK(interrupt_out_n, 1'b1)
    foreach (refuse_tab[i]) begin
      set_chip(refuse_tab[i]);
      cmd(CTM_CAN_NORMAL);
      `CHK(can_mode, CTM_CAN_OFF)
    end
    set_chip(CTM_CHIP_SWFLASH);
    cmd(CTM_CAN_NORMAL);
    `CHK(can_mode, CTM_CAN_NORMAL)
    set_chip(CTM_CHIP_NORMAL);
    @(posedge ref_clk);
    can_tx_input <= 1'b0;
    step(1);
    `CHK(drv_dominant, 1'b1)
    `CHK(drv_enable, 1'b1)
    step(3);
    `CHK(can_rx_output, 1'b0)
    @(posedge ref_clk);
    can_tx_input <= 1'b1;
    step(1);
    `CHK(drv_dominant, 1'b0)
    cmd(CTM_CAN_RXONLY);
    `CHK(drv_enable, 1'b0)
    `CHK(rcv_enable, 1'b1)
    `CHK(lp_rcv_enable, 1'b0)
    // rx pin clamped recessive while the bus toggles
    cmd(CTM_CAN_NORMAL);
    stuck_rx_high <= 1'b1;
    repeat (10) bus_pulse(10);
    `CHK(rx_fail_flag, 1'b1)
    stuck_rx_high <= 1'b0;
    rd(CTM_WAKE_REG_ADDR);
    `CHK(rx_fail_flag, 1'b0)
    foreach (refuse_tab[i]) begin
      set_chip(ctm_chip_type'(i == 0 ? CTM_CHIP_INIT : CTM_CHIP_FACTORY));
      `CHK(can_mode, CTM_CAN_OFF)
      bus_pulse(3 * WF);
      `CHK(can_wake_flag, 1'b0)
      set_chip(CTM_CHIP_NORMAL);
      cmd(CTM_CAN_NORMAL);
    end
    for (int i = 0; i < 7; i++) wake_case(wk_chip[i], wk_mask[i], wk_int_n[i], wk_go[i]);
    // fifo: fill past full with a stalled reader, then drain
    @(posedge ref_clk);
    rx_byte_ready <= 1'b0;
    wake_int_mask <= 1'b0;
    set_chip(CTM_CHIP_NORMAL);
    cmd(CTM_CAN_RXONLY);
    step((CTM_FIFO_DEPTH + 2) * 8 * CTM_BIT_CYC);
    `CHK(rx_overrun, 1'b1)
    cmd(CTM_CAN_OFF);
    for (int i = 0; i < CTM_FIFO_DEPTH; i++) begin
      `CHK(rx_byte_valid, 1'b1)
      `CHK(rx_byte_data, 8'hff)
      @(posedge ref_clk);
      rx_byte_ready <= 1'b1;
      @(posedge ref_clk);
      rx_byte_ready <= 1'b0;
      #1;
    end
    `CHK(rx_byte_valid, 1'b0)
    rd(CTM_WAKE_REG_ADDR);
    `CHK(rx_overrun, 1'b0)
    print_verdict();
  end
endmodule
